// file: pkg/tls_regs.svh
// Constants of the torque limit selector: field values, reset values and scaling.
// Assumes torque is carried in tenths of a percent of motor rated torque.
// Summary of operation
// RULE1: Limiting acts only while open-loop vector control is selected; otherwise torque passes.
// RULE2: The computed torque is clamped so its magnitude never exceeds the effective limit.
// RULE3: Each parameter limit is held in percent of rated torque, 0 to 300, resetting to 200.
// RULE4: Four parameter limits are chosen by quadrant from torque sign and rotation direction.
// RULE5: Analog function codes 10, 11, 12 and 15 select positive, negative, regen and both roles.
// RULE6: The analog input spans 4 to 20 mA, and full scale means 100 percent of rated torque.
// RULE7: The analog limit is multiplied by the gain, so 150.0 percent gives 150 percent at full scale.
// RULE8: The effective limit is the least of parameter, analog and duty-rating ceiling of 150 or 120.
// RULE9: A positive-role analog limit applies whenever torque is positive, regenerating or not.
// RULE10: While the clamp acts, speed control and speed compensation are suspended.
// RULE11: With no torque role selected the analog limit is absent from the minimum.
`ifndef TLS_REGS_SVH
`define TLS_REGS_SVH

`define TLS_CM_VF        2'h0
`define TLS_CM_VF_PG     2'h1
`define TLS_CM_OLV       2'h2

`define TLS_PCT_MAX      9'h12c
`define TLS_PCT_DFLT     9'h0c8

`define TLS_AI_FN_POS    5'h0a
`define TLS_AI_FN_NEG    5'h0b
`define TLS_AI_FN_REGEN  5'h0c
`define TLS_AI_FN_BOTH   5'h0f

// Analog code: 5 uA per count, so 4 mA is 800 and 20 mA is 4000 counts
`define TLS_AI_4MA       12'h320
`define TLS_AI_SPAN      12'hc80
`define TLS_GAIN_DFLT    14'h03e8

`define TLS_DUTY_HEAVY   1'h0
`define TLS_CEIL_HEAVY   11'h5dc
`define TLS_CEIL_LIGHT   11'h4b0
`define TLS_RATIO_UNITY  8'h64

`endif

// file: pkg/tls_pkg.sv
// Types shared by the torque limit selector modules.
// Assumes tls_regs.svh supplies the numeric constants.
package tls_pkg;
  typedef logic signed [15:0] tls_trq_t;
  typedef logic [13:0]        tls_lim_t;
  typedef logic [8:0]         tls_pct_t;
  typedef enum logic [1:0] {
    TLS_Q_FWD_DRIVE,
    TLS_Q_REV_DRIVE,
    TLS_Q_FWD_REGEN,
    TLS_Q_REV_REGEN
  } tls_quad_t;
  typedef enum logic [1:0] {
    TLS_SRC_NONE,
    TLS_SRC_PARAM,
    TLS_SRC_ANALOG,
    TLS_SRC_CEIL
  } tls_src_t;
endpackage : tls_pkg

// file: pkg/tls_lim_if.sv
// Carrier between the selector top and its quadrant and analog helpers.
// Assumes one clock domain; all members are combinational.
`timescale 1ns/1ps
`default_nettype none
interface tls_lim_if #(parameter int ADC_W = 12);
  import tls_pkg::*;
  tls_trq_t           torque_ref;
  logic               motor_fwd;
  tls_quad_t          quadrant;
  logic               trq_positive;
  logic               regen;
  logic [ADC_W-1:0]   analog_code;
  logic [13:0]        analog_gain;
  tls_lim_t           analog_limit;
  modport quad  (input torque_ref, motor_fwd, output quadrant, trq_positive, regen);
  modport scale (input analog_code, analog_gain, output analog_limit);
  modport top   (output torque_ref, motor_fwd, analog_code, analog_gain,
                 input quadrant, trq_positive, regen, analog_limit);
endinterface : tls_lim_if
`default_nettype wire

// file: rtl/tls_quadrant_sel.sv
// Operating quadrant decode from torque sign and rotation direction.
// Assumes zero torque counts as positive torque.
`timescale 1ns/1ps
`default_nettype none
module tls_quadrant_sel
  import tls_pkg::*;
(
  tls_lim_if.quad lif
);
  wire pos_w;
  wire regen_w;

  assign pos_w            = ~lif.torque_ref[15];
  // Torque opposing rotation returns energy to the drive
  assign regen_w          = pos_w ^ lif.motor_fwd; // RULE4
  assign lif.trq_positive = pos_w;
  assign lif.regen        = regen_w;
  assign lif.quadrant     = pos_w ? (lif.motor_fwd ? TLS_Q_FWD_DRIVE : TLS_Q_REV_REGEN)
                                  : (lif.motor_fwd ? TLS_Q_FWD_REGEN : TLS_Q_REV_DRIVE); // RULE4
endmodule : tls_quadrant_sel
`default_nettype wire

// file: rtl/tls_analog_scale.sv
// Scales the synchronised analog code into a torque limit in tenths of a percent.
// Assumes the code is already synchronised; below 4 mA the limit is zero.
`timescale 1ns/1ps
`include "tls_regs.svh"
`default_nettype none
module tls_analog_scale
  import tls_pkg::*;
#(
  parameter int ADC_W = 12
)(
  tls_lim_if.scale lif
);
  localparam int PW = ADC_W + 14;

  wire [ADC_W-1:0] base_w = ADC_W'(`TLS_AI_4MA);
  wire             above_w;
  wire [ADC_W-1:0] diff_w;
  wire [PW-1:0]    prod_w;
  wire [PW-1:0]    quo_w;

  assign above_w = lif.analog_code > base_w; // RULE6
  assign diff_w  = above_w ? ADC_W'(lif.analog_code - base_w) : '0;
  // Span of 3200 counts times gain in tenths of percent lands directly in tenths
  assign prod_w  = PW'(diff_w) * PW'(lif.analog_gain); // RULE7
  assign quo_w   = prod_w / PW'(`TLS_AI_SPAN); // RULE6
  assign lif.analog_limit = (quo_w > PW'(14'h3fff)) ? 14'h3fff : quo_w[13:0];
endmodule : tls_analog_scale
`default_nettype wire

// file: rtl/tls_top.sv
// Torque limit selector: under open-loop vector control, clamps the drive's torque reference to the least of the
// quadrant parameter limit, the optional analog limit and the duty-rating ceiling.
// Assumes torque_ref and settings come from logic on sys_clk; the analog code is
// from a converter in another domain and is synchronised here.
`timescale 1ns/1ps
`include "tls_regs.svh"
`default_nettype none
module tls_top
  import tls_pkg::*;
#(
  parameter int ADC_W = 12
)(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [1:0]       control_method,
  input  wire tls_trq_t         torque_ref,
  input  wire logic             motor_fwd,
  input  wire logic             limit_wr_en,
  input  wire logic [1:0]       limit_wr_idx,
  input  wire logic [8:0]       limit_wr_pct,
  input  wire logic             factory_init,
  input  wire logic [4:0]       aux_analog_function_select,
  input  wire logic [13:0]      aux_analog_gain,
  input  wire logic [ADC_W-1:0] aux_analog_input,
  input  wire logic             duty_rating_select,
  input  wire logic [7:0]       drive_rating_ratio,
  output var  tls_trq_t         torque_out,
  output logic                  torque_limit_active,
  output logic                  speed_ctrl_hold,
  output var  tls_lim_t         effective_limit,
  output var  tls_quad_t        active_quadrant,
  output var  tls_src_t         limit_source,
  output logic                  analog_limit_used,
  output logic                  setting_clamped,
  output logic [8:0]            quadrant_limit_pct
);

  if (ADC_W < 12) begin : g_chk_adc
    $error("ADC_W must reach the 20 mA code of 4000");
  end

  function automatic logic lt14(input tls_lim_t a, input tls_lim_t b);
    lt14 = a < b;
  endfunction : lt14

  function automatic logic [8:0] sat_pct(input logic [8:0] p);
    sat_pct = (p > `TLS_PCT_MAX) ? `TLS_PCT_MAX : p;
  endfunction : sat_pct

  tls_lim_if #(.ADC_W(ADC_W)) lif ();

  // Analog code crosses from the converter domain
  logic [ADC_W-1:0] ai_meta_ff;
  logic [ADC_W-1:0] ai_sync_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ai_meta_ff <= '0;
      ai_sync_ff <= '0;
    end else begin
      ai_meta_ff <= aux_analog_input;
      ai_sync_ff <= ai_meta_ff;
    end
  end

  assign lif.torque_ref  = torque_ref;
  assign lif.motor_fwd   = motor_fwd;
  assign lif.analog_code = ai_sync_ff;
  assign lif.analog_gain = aux_analog_gain;

  tls_quadrant_sel u_quad (
    .lif (lif.quad)
  );

  tls_analog_scale #(.ADC_W(ADC_W)) u_scale (
    .lif (lif.scale)
  );

  // Four quadrant limits, indexed in quadrant order
  logic [8:0] lim_pct_ff [4];
  logic       setting_clamped_ff;

  for (genvar g = 0; g < 4; g++) begin : g_lim
    wire hit_w = limit_wr_en && (limit_wr_idx == 2'(g));
    always_ff @(posedge sys_clk) begin
      if (rst || factory_init) begin
        lim_pct_ff[g] <= `TLS_PCT_DFLT; // RULE3
      end else if (hit_w) begin
        lim_pct_ff[g] <= sat_pct(limit_wr_pct); // RULE3
      end
    end
  end

  wire wr_over_w = limit_wr_en && (limit_wr_pct > `TLS_PCT_MAX);

  // Flag shows whether the most recent write was out of range
  always_ff @(posedge sys_clk) begin
    if (rst || factory_init) begin
      setting_clamped_ff <= 1'b0;
    end else if (limit_wr_en) begin
      setting_clamped_ff <= wr_over_w; // RULE3
    end
  end

  // Parameter limit for the present quadrant, scaled to tenths
  wire [8:0]  qpct_w;
  wire [13:0] par_lim_w;

  assign qpct_w    = lim_pct_ff[lif.quadrant]; // RULE4
  assign par_lim_w = {2'b00, qpct_w, 3'b000} + {4'h0, qpct_w, 1'b0};

  // Analog role decode
  wire role_pos_w;
  wire role_neg_w;
  wire role_regen_w;
  wire role_both_w;
  wire role_any_w;
  wire ana_apply_w;

  assign role_pos_w   = aux_analog_function_select == `TLS_AI_FN_POS; // RULE5
  assign role_neg_w   = aux_analog_function_select == `TLS_AI_FN_NEG; // RULE5
  assign role_regen_w = aux_analog_function_select == `TLS_AI_FN_REGEN; // RULE5
  assign role_both_w  = aux_analog_function_select == `TLS_AI_FN_BOTH; // RULE5
  assign role_any_w   = role_pos_w | role_neg_w | role_regen_w | role_both_w;
  // Positive role keys on torque sign only, so it also covers regeneration
  assign ana_apply_w  = (role_pos_w & lif.trq_positive) // RULE9
                      | (role_neg_w & ~lif.trq_positive)
                      | (role_regen_w & lif.regen)
                      | role_both_w; // RULE11

  // Duty-rating ceiling scaled by drive rating against motor rating
  wire [10:0] ceil_base_w;
  wire [18:0] ceil_prod_w;
  wire [18:0] ceil_quo_w;
  wire [13:0] ceil_lim_w;

  assign ceil_base_w = (duty_rating_select == `TLS_DUTY_HEAVY) ? `TLS_CEIL_HEAVY
                                                              : `TLS_CEIL_LIGHT; // RULE8
  assign ceil_prod_w = 19'(ceil_base_w) * 19'(drive_rating_ratio);
  assign ceil_quo_w  = ceil_prod_w / 19'(`TLS_RATIO_UNITY);
  assign ceil_lim_w  = (ceil_quo_w > 19'h03fff) ? 14'h3fff : ceil_quo_w[13:0];

  // Minimum of the three candidates, remembering which one won
  wire        ceil_wins_w;
  wire [13:0] pc_lim_w;
  wire        ana_wins_w;
  wire [13:0] eff_lim_w;
  tls_src_t   src_w;

  assign ceil_wins_w = lt14(ceil_lim_w, par_lim_w); // RULE8
  assign pc_lim_w    = ceil_wins_w ? ceil_lim_w : par_lim_w;
  assign ana_wins_w  = ana_apply_w && lt14(lif.analog_limit, pc_lim_w); // RULE8
  assign eff_lim_w   = ana_wins_w ? lif.analog_limit : pc_lim_w;
  assign src_w       = ana_wins_w ? TLS_SRC_ANALOG
                     : (ceil_wins_w ? TLS_SRC_CEIL : TLS_SRC_PARAM);

  // Magnitude of the reference, one bit wider so full negative scale survives
  wire        olv_w;
  wire [16:0] ref_ext_w;
  wire [16:0] ref_abs_w;
  wire        over_w;
  wire        clamp_w;
  wire [15:0] eff16_w;
  tls_trq_t   clamped_w;
  tls_trq_t   nxt_torque;

  assign olv_w     = control_method == `TLS_CM_OLV; // RULE1
  assign ref_ext_w = {torque_ref[15], torque_ref};
  assign ref_abs_w = lif.trq_positive ? ref_ext_w : 17'h00000 - ref_ext_w;
  assign over_w    = ref_abs_w > {3'b000, eff_lim_w}; // RULE2
  assign clamp_w   = olv_w && over_w; // RULE1
  assign eff16_w   = {2'b00, eff_lim_w};
  assign clamped_w = lif.trq_positive ? eff16_w : 16'h0000 - eff16_w; // RULE2
  assign nxt_torque = clamp_w ? clamped_w : torque_ref; // RULE2

  tls_trq_t  torque_out_ff;
  logic      limit_active_ff;
  logic      speed_hold_ff;
  tls_lim_t  eff_limit_ff;
  tls_quad_t quad_ff;
  tls_src_t  src_ff;
  logic      ana_used_ff;
  logic [8:0] qpct_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      torque_out_ff   <= 16'h0000;
      limit_active_ff <= 1'b0;
      speed_hold_ff   <= 1'b0;
    end else begin
      torque_out_ff   <= nxt_torque; // RULE2
      limit_active_ff <= clamp_w;
      speed_hold_ff   <= clamp_w; // RULE10
    end
  end

  // Source shows none and analog use clears outside open-loop vector; effective limit and quadrant keep updating
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eff_limit_ff <= 14'h0000;
      quad_ff      <= TLS_Q_FWD_DRIVE;
      src_ff       <= TLS_SRC_NONE;
      ana_used_ff  <= 1'b0;
      qpct_ff      <= `TLS_PCT_DFLT;
    end else begin
      eff_limit_ff <= eff_lim_w;
      quad_ff      <= lif.quadrant;
      src_ff       <= olv_w ? src_w : TLS_SRC_NONE; // RULE1
      ana_used_ff  <= olv_w && ana_wins_w; // RULE11
      qpct_ff      <= qpct_w;
    end
  end

  assign torque_out          = torque_out_ff;
  assign torque_limit_active = limit_active_ff;
  assign speed_ctrl_hold     = speed_hold_ff;
  assign effective_limit     = eff_limit_ff;
  assign active_quadrant     = quad_ff;
  assign limit_source        = src_ff;
  assign analog_limit_used   = ana_used_ff;
  assign setting_clamped     = setting_clamped_ff;
  assign quadrant_limit_pct  = qpct_ff;

endmodule : tls_top
`default_nettype wire

// file: test/tls_drive_model.sv
// Drive torque loop model: hands the torque reference to the selector and
// counts speed compensation steps, frozen while the selector holds speed control.
`timescale 1ns/1ps
`default_nettype none
module tls_drive_model
  import tls_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire tls_trq_t trq_cmd,
  input  wire logic     fwd_cmd,
  input  wire logic     speed_ctrl_hold,
  output var  tls_trq_t torque_ref,
  output logic          motor_fwd,
  output logic [15:0]   comp_steps
);
  initial begin
    torque_ref = 16'h0000;
    motor_fwd = 1'h1;
    comp_steps = 16'h0000;
  end
  // Changes land on the falling edge, well clear of the selector's sampling edge
  always @(negedge sys_clk) begin
    torque_ref <= trq_cmd;
    motor_fwd <= fwd_cmd;
    if (!speed_ctrl_hold) begin
      comp_steps <= comp_steps + 16'h0001;
    end
  end
endmodule : tls_drive_model
`default_nettype wire

// file: test/tls_top_assertions.sv
// Port-level assertions for the torque limit selector.
// Assumes one clock, sys_clk, and synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module tls_top_assertions
  import tls_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [1:0] control_method,
  input wire tls_trq_t   torque_ref,
  input wire logic       motor_fwd,
  input wire logic       limit_wr_en,
  input wire logic       factory_init,
  input wire logic [4:0] aux_analog_function_select,
  input wire logic       duty_rating_select,
  input wire logic [7:0] drive_rating_ratio,
  input wire tls_trq_t   torque_out,
  input wire logic       torque_limit_active,
  input wire logic       speed_ctrl_hold,
  input wire tls_lim_t   effective_limit,
  input wire tls_quad_t  active_quadrant,
  input wire logic       analog_limit_used,
  input wire logic       setting_clamped,
  input wire logic [8:0] quadrant_limit_pct
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic        olv    = control_method == 2'h2;
  wire logic [15:0] imag   = torque_ref[15] ? -torque_ref : torque_ref;
  wire logic [15:0] omag   = torque_out[15] ? -torque_out : torque_out;
  wire logic [15:0] lim    = {2'h0, effective_limit};
  wire logic [18:0] ceil_v = (duty_rating_select ? 19'h4b0 : 19'h5dc) * drive_rating_ratio / 19'h64;
  wire logic        fn_off = !(aux_analog_function_select inside {5'h0a, 5'h0b, 5'h0c, 5'h0f});
  wire tls_quad_t   q_exp  = torque_ref[15] ? (motor_fwd ? TLS_Q_FWD_REGEN : TLS_Q_REV_DRIVE)
                                            : (motor_fwd ? TLS_Q_FWD_DRIVE : TLS_Q_REV_REGEN);
  sequence s_init;
    factory_init ##1 !limit_wr_en;
  endsequence
  property p_pass; !olv |=> torque_out == $past(torque_ref) && !torque_limit_active; endproperty
  property p_clamp;
    olv |=> torque_limit_active == ($past(imag) > lim)
            && (torque_limit_active ? omag == lim : torque_out == $past(torque_ref));
  endproperty
  property p_pct; quadrant_limit_pct <= 9'h12c; endproperty
  property p_init; s_init |-> !setting_clamped ##1 quadrant_limit_pct == 9'h0c8; endproperty
  property p_quad; 1'b1 |=> active_quadrant == $past(q_exp); endproperty
  property p_ceil; 1'b1 |=> {5'h0, effective_limit} <= $past(ceil_v); endproperty
  property p_role;
    fn_off || (aux_analog_function_select == 5'h0a && torque_ref[15]) |=> !analog_limit_used;
  endproperty
  property p_hold; speed_ctrl_hold == torque_limit_active; endproperty
  a_pass: assert property (p_pass) else $error("torque not passed through");
  a_clamp: assert property (p_clamp) else $error("clamp value wrong");
  a_pct: assert property (p_pct) else $error("limit above range");
  a_init: assert property (p_init) else $error("factory init wrong");
  a_quad: assert property (p_quad) else $error("quadrant wrong");
  a_ceil: assert property (p_ceil) else $error("ceiling exceeded");
  a_role: assert property (p_role) else $error("analog used wrongly");
  a_hold: assert property (p_hold) else $error("speed hold mismatch");
endmodule : tls_top_assertions
bind tls_top tls_top_assertions u_chk (
  .sys_clk(sys_clk), .rst(rst), .control_method(control_method), .torque_ref(torque_ref),
  .motor_fwd(motor_fwd), .limit_wr_en(limit_wr_en), .factory_init(factory_init),
  .aux_analog_function_select(aux_analog_function_select),
  .duty_rating_select(duty_rating_select), .drive_rating_ratio(drive_rating_ratio),
  .torque_out(torque_out), .torque_limit_active(torque_limit_active),
  .speed_ctrl_hold(speed_ctrl_hold), .effective_limit(effective_limit),
  .active_quadrant(active_quadrant), .analog_limit_used(analog_limit_used),
  .setting_clamped(setting_clamped), .quadrant_limit_pct(quadrant_limit_pct));
`default_nettype wire

// file: test/test_tls_top.sv
// Self-checking bench for the torque limit selector with a drive loop model.
// Assumes outputs settle one edge after inputs and three after the analog code.
`timescale 1ns/1ps
`default_nettype none
module test_tls_top
  import tls_pkg::*;
();
  typedef struct {int cm, t, fw, fn, c, d, g;} tls_row_t;
  logic sys_clk = 1'h1, rst = 1'h1, fwd_cmd = 1'h1, wr_en = 1'h0, fi = 1'h0, duty = 1'h0;
  logic [1:0] cm = 2'h2, wr_idx = 2'h0;
  logic [8:0] wr_pct = 9'h000;
  logic [4:0] fn = 5'h00;
  logic [13:0] gain = 14'h03e8;
  logic [11:0] code = 12'h000;
  logic [7:0] ratio = 8'h64;
  tls_trq_t trq_cmd = 16'h0000;
  tls_trq_t torque_ref, torque_out;
  logic motor_fwd, act, hold, a_used, s_clamp;
  logic [8:0] q_pct;
  logic [15:0] steps, s;
  tls_lim_t eff;
  tls_quad_t quad;
  tls_src_t src;
  int num_errors = 0, checks_done = 0;
  int lims[4] = '{250, 80, 30, 300};
  tls_row_t rows[17] = '{
    '{2, 2500, 1, 0, 0, 0, 1000}, '{2, 2500, 1, 0, 0, 1, 1000}, '{2, -2500, 0, 0, 0, 0, 1000},
    '{2, -2500, 1, 0, 0, 0, 1000}, '{2, 2500, 0, 0, 0, 0, 1000}, '{2, 300, 1, 0, 0, 0, 1000},
    '{2, 2500, 1, 10, 4000, 0, 1000}, '{2, 2500, 0, 10, 4000, 0, 1000},
    '{2, -2500, 0, 10, 4000, 0, 1000}, '{2, -2500, 0, 11, 2400, 0, 1000},
    '{2, -2500, 0, 12, 4000, 0, 1000}, '{2, -2500, 1, 12, 800, 0, 1000},
    '{2, 2500, 1, 15, 3200, 0, 1500}, '{2, 2500, 1, 15, 500, 0, 1000},
    '{0, 2500, 1, 0, 0, 0, 1000}, '{1, -2500, 1, 15, 4000, 0, 1000}, '{3, 2500, 1, 0, 0, 0, 1000}};
  always #50 sys_clk = ~sys_clk;
  tls_drive_model u_drv (.sys_clk(sys_clk), .trq_cmd(trq_cmd), .fwd_cmd(fwd_cmd),
    .speed_ctrl_hold(hold), .torque_ref(torque_ref), .motor_fwd(motor_fwd), .comp_steps(steps));
  tls_top u_dut (.sys_clk(sys_clk), .rst(rst), .control_method(cm), .torque_ref(torque_ref),
    .motor_fwd(motor_fwd), .limit_wr_en(wr_en), .limit_wr_idx(wr_idx), .limit_wr_pct(wr_pct),
    .factory_init(fi), .aux_analog_function_select(fn), .aux_analog_gain(gain),
    .aux_analog_input(code), .duty_rating_select(duty), .drive_rating_ratio(ratio),
    .torque_out(torque_out), .torque_limit_active(act), .speed_ctrl_hold(hold),
    .effective_limit(eff), .active_quadrant(quad), .limit_source(src),
    .analog_limit_used(a_used), .setting_clamped(s_clamp), .quadrant_limit_pct(q_pct));
  function automatic int qd(tls_row_t r);
    return r.t >= 0 ? (r.fw ? 0 : 3) : (r.fw ? 2 : 1);
  endfunction : qd
  function automatic int exp_lim(tls_row_t r);
    int l, a, cl;
    l = lims[qd(r)] * 10;
    cl = (r.d ? 1200 : 1500) * int'(ratio) / 100;
    a = r.c < 800 ? 0 : (r.c - 800) * r.g / 3200;
    if (l > cl) l = cl;
    if ((r.fn == 10 && r.t >= 0) || (r.fn == 11 && r.t < 0) || r.fn == 15
        || (r.fn == 12 && qd(r) > 1)) l = a < l ? a : l;
    return l;
  endfunction : exp_lim
  // Which candidate wins: 0 outside open-loop vector, 1 parameter, 2 analog, 3 ceiling
  function automatic int exp_src(tls_row_t r);
    int l, a, cl, s;
    l = lims[qd(r)] * 10;
    cl = (r.d ? 1200 : 1500) * int'(ratio) / 100;
    a = r.c < 800 ? 0 : (r.c - 800) * r.g / 3200;
    s = 1;
    if (cl < l) begin
      l = cl;
      s = 3;
    end
    if (((r.fn == 10 && r.t >= 0) || (r.fn == 11 && r.t < 0) || r.fn == 15
        || (r.fn == 12 && qd(r) > 1)) && a < l) s = 2;
    return r.cm != 2 ? 0 : s;
  endfunction : exp_src
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
    checks_done++;
    if (v !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask : chk
  task automatic wr(input logic [1:0] i, input logic [8:0] p);
    @(negedge sys_clk);
    wr_en <= 1'h1;
    wr_idx <= i;
    wr_pct <= p;
    @(negedge sys_clk);
    wr_en <= 1'h0;
  endtask : wr
  task automatic run_row(input tls_row_t r);
    int e, o, q, sx;
    @(negedge sys_clk);
    cm <= r.cm[1:0];
    trq_cmd <= r.t[15:0];
    fwd_cmd <= r.fw[0];
    fn <= r.fn[4:0];
    code <= r.c[11:0];
    duty <= r.d[0];
    gain <= r.g[13:0];
    repeat (5) @(negedge sys_clk);
    e = exp_lim(r);
    q = qd(r);
    sx = exp_src(r);
    o = r.cm != 2 ? r.t : r.t > e ? e : r.t < -e ? -e : r.t;
    chk("torque_out", o[15:0], torque_out);
    chk("effective_limit", e[15:0], {2'h0, eff});
    chk("active_quadrant", q[15:0], {14'h0, quad});
    chk("speed_ctrl_hold", {15'h0, o != r.t}, {15'h0, hold});
    chk("limit_source", sx[15:0], {14'h0, src});
    chk("analog_limit_used", {15'h0, sx == 2}, {15'h0, a_used});
  endtask : run_row
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(negedge sys_clk);
    rst <= 1'h0;
    chk("reset_pct", 16'h00c8, {7'h0, q_pct});
    chk("reset_out", 16'h0000, torque_out);
    wr(2'h0, 9'h0fa);
    wr(2'h1, 9'h050);
    wr(2'h2, 9'h01e);
    wr(2'h3, 9'h15f);
    run_row(rows[4]);
    chk("setting_clamped", 16'h0001, {15'h0, s_clamp});
    chk("saturated_pct", 16'h012c, {7'h0, q_pct});
    foreach (rows[i]) run_row(rows[i]);
    // A clamping drive must freeze speed compensation; a free one keeps stepping
    run_row(rows[0]);
    s = steps;
    repeat (4) @(negedge sys_clk);
    chk("comp_frozen", s, steps);
    run_row(rows[5]);
    s = steps;
    repeat (4) @(negedge sys_clk);
    chk("comp_running", s + 16'h0004, steps);
    ratio <= 8'h50;
    run_row(rows[0]);
    @(negedge sys_clk);
    fi <= 1'h1;
    wr_en <= 1'h1;
    wr_pct <= 9'h1ff;
    @(negedge sys_clk);
    fi <= 1'h0;
    wr_en <= 1'h0;
    repeat (2) @(negedge sys_clk);
    chk("factory_pct", 16'h00c8, {7'h0, q_pct});
    chk("factory_clamp", 16'h0000, {15'h0, s_clamp});
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end
endmodule : test_tls_top
`default_nettype wire
